//--- rtl/sfcr_consts.vh
// Constants for the SPI flash configuration router.
`ifndef SFCR_CONSTS_VH
`define SFCR_CONSTS_VH

// ----------------------------------------------------------------------
// Clock and serial timing
// ----------------------------------------------------------------------
`define SFCR_CLOCK_MHZ          40
`define SFCR_CFG_SCLK_MHZ       5
`define SFCR_CFG_HALF_CYCLES    (`SFCR_CLOCK_MHZ / (2 * `SFCR_CFG_SCLK_MHZ))
`define SFCR_PHASE_WIDTH        3

// ----------------------------------------------------------------------
// Self-configuration read sequence
// ----------------------------------------------------------------------
`define SFCR_READ_OPCODE        8'h03
`define SFCR_READ_ADDRESS       24'h000000
`define SFCR_CMD_BITS           24'h000020
`define SFCR_BITSTREAM_BITS     24'h040000
`define SFCR_BIT_COUNT_WIDTH    24

// ----------------------------------------------------------------------
// Operating modes after configuration
// ----------------------------------------------------------------------
`define SFCR_MODE_IDLE          3'h0
`define SFCR_MODE_PROG_CONFIG   3'h1
`define SFCR_MODE_PROG_AUX_ONE  3'h2
`define SFCR_MODE_PROG_AUX_TWO  3'h3
`define SFCR_MODE_LOAD_PHY_ONE  3'h4
`define SFCR_MODE_LOAD_PHY_TWO  3'h5

// ----------------------------------------------------------------------
// Synchroniser bit positions
// ----------------------------------------------------------------------
`define SFCR_SYNC_WIDTH         8
`define SFCR_SYNC_DIN           0
`define SFCR_SYNC_SECONDARY     1
`define SFCR_SYNC_P1_SEL_N      2
`define SFCR_SYNC_P1_CLK        3
`define SFCR_SYNC_P1_MOSI       4
`define SFCR_SYNC_P2_SEL_N      5
`define SFCR_SYNC_P2_CLK        6
`define SFCR_SYNC_P2_MOSI       7

`endif

//--- rtl/sfcr_sync.v
// Two-flop synchroniser for a group of asynchronous pin inputs.
module sfcr_sync #(
    parameter WIDTH = 1
) (
    clock,
    reset,
    asyncIn,
    syncOut
);
    input  wire             clock;
    input  wire             reset;
    input  wire [WIDTH-1:0] asyncIn;
    output wire [WIDTH-1:0] syncOut;

    reg [WIDTH-1:0] stageOne_q;
    reg [WIDTH-1:0] stageTwo_q;

    // The first stage feeds only the second stage.
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            stageOne_q <= {WIDTH{1'b0}};
            stageTwo_q <= {WIDTH{1'b0}};
        end else begin
            stageOne_q <= asyncIn;
            stageTwo_q <= stageOne_q;
        end
    end

    assign syncOut = stageTwo_q;
endmodule

//--- rtl/sfcr_spi_flash_config_router.v
// SPI flash router: self-configuration loader and flash path steering.
//
// Operation
// - Load bitstream from PROM before other functions.
// - Loader drives select, clock, MOSI; samples data.
// - Aux selects stay high while unconfigured.
// - Primary PROM by default; secondary on request.
// - Local-bus SPI controller drives configuration flash.
// - Aux selects high during configuration programming.
// - Aux one programming: config select held high.
// - Aux two programming: config select held high.
// - First PHY port routed to aux one path.
// - Second PHY ports routed to aux two path.
`include "sfcr_consts.vh"

module sfcr_spi_flash_config_router #(
    parameter BITSTREAM_BITS = `SFCR_BITSTREAM_BITS
) (
    clock,
    reset,
    modeSelect,
    ctrlSelect,
    ctrlClock,
    ctrlMosi,
    ctrlMiso,
    secondaryRequest,
    flashDataIn,
    phyOneSelect_n,
    phyOneClock,
    phyOneMosi,
    phyOneMiso,
    phyTwoSelect_n,
    phyTwoClock,
    phyTwoMosi,
    phyTwoMiso,
    config_flash_select_n,
    config_serial_clock,
    flashMosi,
    aux_flash_select_one_n,
    aux_flash_select_two_n,
    configSourceSecondary,
    bitstreamBit,
    bitstreamValid,
    configDone
);
    input  wire       clock;
    input  wire       reset;
    input  wire [2:0] modeSelect;
    input  wire       ctrlSelect;
    input  wire       ctrlClock;
    input  wire       ctrlMosi;
    output reg        ctrlMiso;
    input  wire       secondaryRequest;
    input  wire       flashDataIn;
    input  wire       phyOneSelect_n;
    input  wire       phyOneClock;
    input  wire       phyOneMosi;
    output reg        phyOneMiso;
    input  wire       phyTwoSelect_n;
    input  wire       phyTwoClock;
    input  wire       phyTwoMosi;
    output reg        phyTwoMiso;
    output reg        config_flash_select_n;
    output reg        config_serial_clock;
    output reg        flashMosi;
    output reg        aux_flash_select_one_n;
    output reg        aux_flash_select_two_n;
    output reg        configSourceSecondary;
    output reg        bitstreamBit;
    output reg        bitstreamValid;
    output reg        configDone;

    // ------------------------------------------------------------------
    // Loader states and local constants
    // ------------------------------------------------------------------
    localparam [3:0] ST_START = 4'h1;
    localparam [3:0] ST_CMD   = 4'h2;
    localparam [3:0] ST_DATA  = 4'h4;
    localparam [3:0] ST_DONE  = 4'h8;
    // Full-width terminal counts, cut to the counter widths below.
    localparam [31:0] PHASE_FULL = `SFCR_CFG_HALF_CYCLES - 1;
    localparam [31:0] DATA_FULL  = BITSTREAM_BITS - 1;
    localparam [`SFCR_PHASE_WIDTH-1:0] PHASE_LAST =
        PHASE_FULL[`SFCR_PHASE_WIDTH-1:0];
    localparam [`SFCR_BIT_COUNT_WIDTH-1:0] DATA_LAST =
        DATA_FULL[`SFCR_BIT_COUNT_WIDTH-1:0];
    localparam [`SFCR_BIT_COUNT_WIDTH-1:0] CMD_LAST  = `SFCR_CMD_BITS - 1'b1;

    wire [`SFCR_SYNC_WIDTH-1:0] pinSync;

    reg [3:0]                       state_q;
    reg [3:0]                       state_d;
    reg [`SFCR_PHASE_WIDTH-1:0]     phase_q;
    reg                             loadClock_q;
    reg [31:0]                      shiftOut_q;
    reg [`SFCR_BIT_COUNT_WIDTH-1:0] bitCount_q;
    reg [1:0]                       captureWait_q;

    wire phaseWrap = (phase_q == PHASE_LAST);
    wire clockFall = phaseWrap && loadClock_q;
    wire dataIn    = pinSync[`SFCR_SYNC_DIN];

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // Every pin from the flashes and the PHYs, and the secondary request,
    // passes two flops before use; the local-bus ctrl pins do not.
    sfcr_sync #(
        .WIDTH (`SFCR_SYNC_WIDTH)
    ) u_pin_sync (
        .clock   (clock),
        .reset   (reset),
        .asyncIn ({phyTwoMosi, phyTwoClock, phyTwoSelect_n,
                   phyOneMosi, phyOneClock, phyOneSelect_n,
                   secondaryRequest, flashDataIn}),
        .syncOut (pinSync)
    );

    // ------------------------------------------------------------------
    // Source selection capture
    // ------------------------------------------------------------------
    // Primary stays selected unless the request is high after reset.
    // The synchroniser is cleared by reset as well, so the capture waits
    // until its second stage holds a sample taken after reset ended.
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            captureWait_q         <= 2'h0;
            configSourceSecondary <= 1'b0;
        end else if (captureWait_q != 2'h3) begin
            captureWait_q <= captureWait_q + 2'h1;
            if (captureWait_q == 2'h2) begin
                configSourceSecondary <= pinSync[`SFCR_SYNC_SECONDARY];
            end
        end
    end

    // ------------------------------------------------------------------
    // Self-configuration loader
    // ------------------------------------------------------------------
    // Next state of the loader; it sends a read command and then streams
    // the bitstream, advancing on falling edges of its own clock.
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_START: state_d = ST_CMD;
            ST_CMD: begin
                if (clockFall && bitCount_q == CMD_LAST) begin
                    state_d = ST_DATA;
                end
            end
            ST_DATA: begin
                if (clockFall && bitCount_q == DATA_LAST) begin
                    state_d = ST_DONE;
                end
            end
            ST_DONE:  state_d = ST_DONE;
            default:  state_d = ST_START;
        endcase
    end

    // Clock divider, command shifter and bitstream sampling.
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            state_q        <= ST_START;
            phase_q        <= {`SFCR_PHASE_WIDTH{1'b0}};
            loadClock_q    <= 1'b0;
            shiftOut_q     <= 32'h00000000;
            bitCount_q     <= {`SFCR_BIT_COUNT_WIDTH{1'b0}};
            bitstreamBit   <= 1'b0;
            bitstreamValid <= 1'b0;
            configDone     <= 1'b0;
        end else begin
            state_q        <= state_d;
            bitstreamValid <= 1'b0;
            if (state_q == ST_START) begin
                shiftOut_q <= {`SFCR_READ_OPCODE, `SFCR_READ_ADDRESS};
                phase_q    <= {`SFCR_PHASE_WIDTH{1'b0}};
                bitCount_q <= {`SFCR_BIT_COUNT_WIDTH{1'b0}};
            end else if (state_q == ST_CMD || state_q == ST_DATA) begin
                phase_q <= phaseWrap ? {`SFCR_PHASE_WIDTH{1'b0}} :
                           phase_q + 1'b1;
                if (phaseWrap) begin
                    loadClock_q <= ~loadClock_q;
                end
                if (clockFall) begin
                    shiftOut_q <= {shiftOut_q[30:0], 1'b0};
                    if (state_d != state_q) begin
                        bitCount_q <= {`SFCR_BIT_COUNT_WIDTH{1'b0}};
                    end else begin
                        bitCount_q <= bitCount_q + 1'b1;
                    end
                end
                if (clockFall && state_q == ST_DATA) begin
                    bitstreamBit   <= dataIn;
                    bitstreamValid <= 1'b1;
                end
            end else begin
                loadClock_q <= 1'b0;
            end
            if (state_q == ST_DATA && state_d == ST_DONE) begin
                configDone <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Flash path steering
    // ------------------------------------------------------------------
    // All flash-facing pins come from flops; before configuration the
    // loader owns them, afterwards the selected mode does.
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            config_flash_select_n  <= 1'b1;
            config_serial_clock    <= 1'b0;
            flashMosi              <= 1'b0;
            aux_flash_select_one_n <= 1'b1;
            aux_flash_select_two_n <= 1'b1;
            ctrlMiso               <= 1'b0;
            phyOneMiso             <= 1'b0;
            phyTwoMiso             <= 1'b0;
        end else if (!configDone) begin
            config_flash_select_n  <= !(state_q == ST_CMD || state_q == ST_DATA);
            config_serial_clock    <= loadClock_q;
            flashMosi              <= shiftOut_q[31];
            aux_flash_select_one_n <= 1'b1;
            aux_flash_select_two_n <= 1'b1;
            ctrlMiso               <= 1'b0;
            phyOneMiso             <= 1'b0;
            phyTwoMiso             <= 1'b0;
        end else begin
            config_flash_select_n  <= 1'b1;
            config_serial_clock    <= 1'b0;
            flashMosi              <= 1'b0;
            aux_flash_select_one_n <= 1'b1;
            aux_flash_select_two_n <= 1'b1;
            ctrlMiso               <= 1'b0;
            phyOneMiso             <= 1'b0;
            phyTwoMiso             <= 1'b0;
            case (modeSelect)
                `SFCR_MODE_PROG_CONFIG: begin
                    config_flash_select_n <= !ctrlSelect;
                    config_serial_clock   <= ctrlClock;
                    flashMosi             <= ctrlMosi;
                    ctrlMiso              <= dataIn;
                end
                `SFCR_MODE_PROG_AUX_ONE: begin
                    aux_flash_select_one_n <= !ctrlSelect;
                    config_serial_clock    <= ctrlClock;
                    flashMosi              <= ctrlMosi;
                    ctrlMiso               <= dataIn;
                end
                `SFCR_MODE_PROG_AUX_TWO: begin
                    aux_flash_select_two_n <= !ctrlSelect;
                    config_serial_clock    <= ctrlClock;
                    flashMosi              <= ctrlMosi;
                    ctrlMiso               <= dataIn;
                end
                `SFCR_MODE_LOAD_PHY_ONE: begin
                    aux_flash_select_one_n <= pinSync[`SFCR_SYNC_P1_SEL_N];
                    config_serial_clock    <= pinSync[`SFCR_SYNC_P1_CLK];
                    flashMosi              <= pinSync[`SFCR_SYNC_P1_MOSI];
                    phyOneMiso             <= dataIn;
                end
                `SFCR_MODE_LOAD_PHY_TWO: begin
                    aux_flash_select_two_n <= pinSync[`SFCR_SYNC_P2_SEL_N];
                    config_serial_clock    <= pinSync[`SFCR_SYNC_P2_CLK];
                    flashMosi              <= pinSync[`SFCR_SYNC_P2_MOSI];
                    phyTwoMiso             <= dataIn;
                end
                default: begin
                    config_serial_clock <= 1'b0;
                end
            endcase
        end
    end
endmodule

//--- verif/sfcr_router_sva.sv
// Concurrent checks on the ports of the SPI flash router.
module sfcr_router_sva (
    input logic       clock,
    input logic       reset,
    input logic [2:0] modeSelect,
    input logic       ctrlSelect,
    input logic       ctrlClock,
    input logic       ctrlMosi,
    input logic       phyOneSelect_n,
    input logic       phyOneClock,
    input logic       phyTwoSelect_n,
    input logic       phyTwoMosi,
    input logic       config_flash_select_n,
    input logic       config_serial_clock,
    input logic       flashMosi,
    input logic       aux_flash_select_one_n,
    input logic       aux_flash_select_two_n,
    input logic       configSourceSecondary,
    input logic       bitstreamValid,
    input logic       configDone
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    // All three selects as one word: config, aux one, aux two.
    wire [2:0] allSel_n = {config_flash_select_n, aux_flash_select_one_n, aux_flash_select_two_n};
    wire       run      = configDone;

    property p_oneSel; allSel_n inside {3'h7, 3'h6, 3'h5, 3'h3}; endproperty
    a_oneSel: assert property (p_oneSel) else $error("two selects low");
    property p_auxUnconf; !run |-> allSel_n[1:0] == 2'h3; endproperty
    a_auxUnconf: assert property (p_auxUnconf) else $error("aux select while loading");
    property p_idle; run && modeSelect == 3'h0 |=> allSel_n == 3'h7 && !config_serial_clock;
    endproperty
    a_idle: assert property (p_idle) else $error("idle not quiet");
    property p_progCfg; run && modeSelect == 3'h1 |=> allSel_n == {~$past(ctrlSelect), 2'h3}
        && config_serial_clock == $past(ctrlClock); endproperty
    a_progCfg: assert property (p_progCfg) else $error("config programming path");
    property p_progAuxOne; run && modeSelect == 3'h2 |=>
        allSel_n == {1'h1, ~$past(ctrlSelect), 1'h1} && flashMosi == $past(ctrlMosi); endproperty
    a_progAuxOne: assert property (p_progAuxOne) else $error("aux one programming");
    property p_progAuxTwo; run && modeSelect == 3'h3 |=> allSel_n == {2'h3, ~$past(ctrlSelect)};
    endproperty
    a_progAuxTwo: assert property (p_progAuxTwo) else $error("aux two programming");
    property p_loadOne; run && modeSelect == 3'h4 |=> allSel_n == {1'h1, $past(phyOneSelect_n, 3),
        1'h1} && config_serial_clock == $past(phyOneClock, 3); endproperty
    a_loadOne: assert property (p_loadOne) else $error("first port routing");
    property p_loadTwo; run && modeSelect == 3'h5 |=> allSel_n == {2'h3, $past(phyTwoSelect_n, 3)}
        && flashMosi == $past(phyTwoMosi, 3); endproperty
    a_loadTwo: assert property (p_loadTwo) else $error("second port routing");
    property p_pulse; bitstreamValid |=> !bitstreamValid [*7]; endproperty
    a_pulse: assert property (p_pulse) else $error("bit pulse spacing");
    property p_secStable; run |-> $stable(configSourceSecondary); endproperty
    a_secStable: assert property (p_secStable) else $error("source changed");
    property p_doneStick; run |=> run; endproperty
    a_doneStick: assert property (p_doneStick) else $error("done dropped");

    c_done: cover property ($rose(configDone));
    c_loadOne: cover property (run && modeSelect == 3'h4 && !aux_flash_select_one_n);
    c_loadTwo: cover property (run && modeSelect == 3'h5 && !aux_flash_select_two_n);
endmodule

bind sfcr_spi_flash_config_router sfcr_router_sva u_sva (
    .clock(clock), .reset(reset), .modeSelect(modeSelect), .ctrlSelect(ctrlSelect),
    .ctrlClock(ctrlClock), .ctrlMosi(ctrlMosi), .phyOneSelect_n(phyOneSelect_n),
    .phyOneClock(phyOneClock), .phyTwoSelect_n(phyTwoSelect_n), .phyTwoMosi(phyTwoMosi),
    .config_flash_select_n(config_flash_select_n), .config_serial_clock(config_serial_clock),
    .flashMosi(flashMosi), .aux_flash_select_one_n(aux_flash_select_one_n),
    .aux_flash_select_two_n(aux_flash_select_two_n),
    .configSourceSecondary(configSourceSecondary), .bitstreamValid(bitstreamValid),
    .configDone(configDone)
);

//--- verif/sfcr_flash_model.sv
// Behavioural serial flash that answers a read with a repeating byte pattern.
module sfcr_flash_model #(
    parameter logic [7:0] PATTERN = 8'hA5,
    parameter int         LAG_NS  = 0
) (
    input  logic        select_n,
    input  logic        sclk,
    input  logic        mosi,
    output logic        miso,
    output logic [31:0] cmdWord
);
    timeunit 1ns;
    timeprecision 100ps;
    int riseCount = 0;
    initial miso = 1'b0;
    initial cmdWord = 32'h0;

    // Each selection starts a fresh command.
    always @(negedge select_n) riseCount = 0;
    // Command and address bits are taken on rising edges, first bit first.
    always @(posedge sclk) if (!select_n) begin
        if (riseCount < 32) cmdWord <= {cmdWord[30:0], mosi};
        riseCount <= riseCount + 1;
    end
    // Data shifts out after falling edges once the full command is in.
    always @(negedge sclk) if (!select_n && riseCount >= 32) begin
        miso <= #(LAG_NS) PATTERN[7 - ((riseCount - 32) % 8)];
    end
    // A released line has no pull, so it shows the inverse of its last level.
    always @(posedge select_n) miso <= #(LAG_NS) ~miso;
endmodule

//--- verif/sfcr_spi_flash_config_router_tb.sv
// Self-checking bench for the SPI flash router.
module sfcr_spi_flash_config_router_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int         BITS    = 64;
    localparam logic [7:0] PAT_ONE = 8'hA5;
    localparam logic [7:0] PAT_TWO = 8'h3C;
    logic        clock = 0, reset = 1, secReq = 0;
    logic        ctrlSelect = 0, ctrlClock = 0, ctrlMosi = 0;
    logic        phySel_n = 1, phyClk = 0, phyMosi = 0, linkRun = 0, dinHigh = 0;
    logic [2:0]  modeSelect = 3'h0;
    wire         flashDataIn, cfgSel_n, sclk, mosi, aux1_n, aux2_n, miso1, miso2;
    wire         secondary, bitBit, bitValid, done, ctrlMisoOut, phyMiso1, phyMiso2;
    wire  [31:0] cmd1, cmd2;
    int          fails = 0, n_checks = 0, cycles = 0;

    sfcr_spi_flash_config_router #(.BITSTREAM_BITS(BITS)) dut (
        .clock(clock), .reset(reset), .modeSelect(modeSelect), .ctrlSelect(ctrlSelect),
        .ctrlClock(ctrlClock), .ctrlMosi(ctrlMosi), .ctrlMiso(ctrlMisoOut),
        .secondaryRequest(secReq), .flashDataIn(flashDataIn),
        .phyOneSelect_n(phySel_n), .phyOneClock(phyClk), .phyOneMosi(phyMosi),
        .phyOneMiso(phyMiso1),
        .phyTwoSelect_n(phySel_n), .phyTwoClock(phyClk), .phyTwoMosi(phyMosi),
        .phyTwoMiso(phyMiso2),
        .config_flash_select_n(cfgSel_n), .config_serial_clock(sclk), .flashMosi(mosi),
        .aux_flash_select_one_n(aux1_n), .aux_flash_select_two_n(aux2_n),
        .configSourceSecondary(secondary), .bitstreamBit(bitBit),
        .bitstreamValid(bitValid), .configDone(done));
    // The management controller steers the select and data line to one flash.
    sfcr_flash_model #(.PATTERN(PAT_ONE), .LAG_NS(0)) flashOne (.select_n(cfgSel_n | secReq),
        .sclk(sclk), .mosi(mosi), .miso(miso1), .cmdWord(cmd1));
    sfcr_flash_model #(.PATTERN(PAT_TWO), .LAG_NS(30)) flashTwo (.select_n(cfgSel_n | ~secReq),
        .sclk(sclk), .mosi(mosi), .miso(miso2), .cmdWord(cmd2));
    // The routing scenario can hold the shared data line high to see where it goes.
    assign flashDataIn = dinHigh | (secReq ? miso2 : miso1);

    // System clock, and a link clock that runs only within frames and parks low.
    initial forever #12.5 clock = ~clock;
    always #100 if (linkRun || phyClk) phyClk = ~phyClk;
    // Cut a hang short.
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            report_and_stop();
        end
    end

    task automatic cyc(int n = 1);
        repeat (n) @(posedge clock);
        #2;
    endtask
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic report_and_stop();
        if (fails == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // Load from the chosen flash while a programming request waits.
    task automatic t_load(logic sec, logic [7:0] pat);
        int k;
        int n;
        k = 0;
        reset = 1;
        secReq = sec;
        modeSelect = 3'h2;
        ctrlSelect = 1;
        cyc(10);
        reset = 0;
        for (n = 0; n < 2000 && done !== 1'b1; n++) begin
            cyc();
            if (bitValid === 1'b1) begin
                chk("bitstream bit", pat[7 - k % 8], bitBit);
                k++;
            end
        end
        chk("bit count", BITS, k);
        chk("read command", 32'h03000000, sec ? cmd2 : cmd1);
        chk("source", sec, secondary);
        modeSelect = 3'h0;
        ctrlSelect = 0;
    endtask

    // Every mode code with all sources active, then released.
    task automatic t_route();
        logic [2:0] expSel;
        ctrlClock = 1;
        ctrlMosi = 1;
        phyMosi = 1;
        dinHigh = 1;
        for (int m = 0; m < 8; m++) begin
            modeSelect = m[2:0];
            ctrlSelect = 1;
            phySel_n = 0;
            linkRun = (m == 4 || m == 5);
            cyc(5);
            case (m)
                1: expSel = 3'h3;
                2, 4: expSel = 3'h5;
                3, 5: expSel = 3'h6;
                default: expSel = 3'h7;
            endcase
            chk("selects", expSel, {cfgSel_n, aux1_n, aux2_n});
            if (m < 4 || m > 5) chk("serial clock", m > 0 && m < 4, sclk);
            if (m > 0 && m < 6) chk("mosi", 1, mosi);
            chk("ctrl miso", m > 0 && m < 4, ctrlMisoOut);
            chk("phy one miso", m == 4, phyMiso1);
            chk("phy two miso", m == 5, phyMiso2);
            linkRun = 0;
            phySel_n = 1;
            ctrlSelect = 0;
            cyc(4);
            chk("released", 3'h7, {cfgSel_n, aux1_n, aux2_n});
        end
        dinHigh = 0;
    endtask

    initial begin
        t_load(1'b0, PAT_ONE);
        t_route();
        t_load(1'b1, PAT_TWO);
        t_route();
        report_and_stop();
    end
endmodule
